// ---- rtl/qbtp_pkg.sv ----
package qbtp_pkg;

  localparam int unsigned WORD_WIDTH = 4;

  typedef logic [WORD_WIDTH-1:0] qbtp_word_type;

  // Bus pin carrier: level driven, drive enable.
  typedef struct packed {
    qbtp_word_type data;
    logic          enable;
  } qbtp_drive_type;

  // Receive pin carrier for the three-state received-word outputs.
  typedef struct packed {
    qbtp_word_type data;
    logic          enable;
  } qbtp_recv_type;

  localparam logic [1:0] SYNC_STAGES = 2'h2;

endpackage

// ---- rtl/qbtp_sync.sv ----
`timescale 1ns/1ps
module qbtp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // The first stage is read only by the second stage.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule

// ---- rtl/qbtp_transceiver.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Capture send word on capture clock rise.
// - Inhibit high floats bus, low drives.
// - Bus line carries inverted register bit.
// - Receiver takes inverted bus line.
// - Own driven value feeds receivers internally.
// - Hold low keeps receive latches transparent.
// - Hold high freezes received word.
// - Output disable high floats received word.
// - Driving: parity over send inputs.
// - Inhibited: parity over receiver latches.
// - Parity is XOR of selected four bits.
module qbtp_transceiver (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire qbtp_pkg::qbtp_word_type send_word,
  input  wire logic                   driver_capture_clock,
  input  wire logic                   bus_drive_inhibit,
  input  wire logic                   receive_hold,
  input  wire logic                   receive_output_disable,
  input  wire qbtp_pkg::qbtp_word_type bus_in,
  output qbtp_pkg::qbtp_drive_type    bus_out,
  output qbtp_pkg::qbtp_recv_type     receive_out,
  output logic                        parity_odd
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation. Every pin is sampled into the clock domain, so the
  // logic below sees the pins two cycles late and the registered outputs follow
  // one cycle after that; the capture clock is only seen as a level, which limits it to well under half the system rate.

  localparam int unsigned SYNC_WIDTH = 2 * qbtp_pkg::WORD_WIDTH + 4;

  logic [SYNC_WIDTH-1:0] pins_raw;
  logic [SYNC_WIDTH-1:0] pins_sync;

  // The two enables pass the synchroniser inverted, so that its cleared
  // stages read as inhibited and disabled. Otherwise the bus would be driven
  // for two cycles after reset, before the real pin level arrives.
  assign pins_raw = {send_word, bus_in, driver_capture_clock,
                     ~bus_drive_inhibit, receive_hold,
                     ~receive_output_disable};

  qbtp_sync #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  qbtp_pkg::qbtp_word_type send_s;
  qbtp_pkg::qbtp_word_type bus_s;
  logic                    capture_s;
  logic                    inhibit_s;
  logic                    hold_s;
  logic                    out_disable_s;
  logic                    drive_en_s;
  logic                    recv_en_s;

  assign {send_s, bus_s, capture_s, drive_en_s, hold_s, recv_en_s} =
    pins_sync;
  assign inhibit_s     = !drive_en_s;
  assign out_disable_s = !recv_en_s;

  ////////////////////////////////////////////////////////////////////////////
  // State. The reset only gives simulation defined values; the device itself
  // has none, so a user must load before relying on the contents.

  logic                    capture_last_reg;
  logic                    capture_last_next;
  qbtp_pkg::qbtp_word_type driver_reg;
  qbtp_pkg::qbtp_word_type driver_next;
  qbtp_pkg::qbtp_word_type latch_reg;
  qbtp_pkg::qbtp_word_type latch_next;
  qbtp_pkg::qbtp_drive_type bus_out_reg;
  qbtp_pkg::qbtp_drive_type bus_out_next;
  qbtp_pkg::qbtp_recv_type  receive_out_reg;
  qbtp_pkg::qbtp_recv_type  receive_out_next;
  logic                    parity_reg;
  logic                    parity_next;
  qbtp_pkg::qbtp_word_type line_level;

  always_comb begin
    capture_last_next = capture_s;
    driver_next       = driver_reg;
    if (capture_s && !capture_last_reg) begin
      driver_next = send_s;
    end
    // While driving, the receivers see our own value rather than the pins,
    // which avoids a round trip through the pad synchronisers.
    if (!inhibit_s) begin
      line_level = ~driver_reg;
    end else begin
      line_level = bus_s;
    end
    latch_next = latch_reg;
    if (!hold_s) begin
      latch_next = ~line_level;
    end
    bus_out_next.data   = ~driver_next;
    bus_out_next.enable = !inhibit_s;
    receive_out_next.data   = latch_next;
    receive_out_next.enable = !out_disable_s;
    if (!inhibit_s) begin
      parity_next = ^send_s;
    end else begin
      parity_next = ^latch_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      capture_last_reg <= 1'h0;
      driver_reg       <= '0;
      latch_reg        <= '0;
      bus_out_reg      <= '0;
      receive_out_reg  <= '0;
      parity_reg       <= 1'h0;
    end else begin
      capture_last_reg <= capture_last_next;
      driver_reg       <= driver_next;
      latch_reg        <= latch_next;
      bus_out_reg      <= bus_out_next;
      receive_out_reg  <= receive_out_next;
      parity_reg       <= parity_next;
    end
  end

  assign bus_out     = bus_out_reg;
  assign receive_out = receive_out_reg;
  assign parity_odd  = parity_reg;

endmodule

// ---- tb/qbtp_peer.sv ----
`timescale 1ns/1ps
module qbtp_peer (
  input  wire logic                    clock,
  input  wire logic                    en,
  input  wire qbtp_pkg::qbtp_word_type  val,
  input  wire qbtp_pkg::qbtp_drive_type dev,
  output qbtp_pkg::qbtp_word_type       bus
);
  qbtp_pkg::qbtp_word_type last_reg;
  always_ff @(posedge clock) last_reg <= bus;
  // A floating bus shows the inverse of its last level, never a stale value.
  assign bus = dev.enable ? dev.data : (en ? val : ~last_reg);
endmodule

// ---- tb/qbtp_assertions.sv ----
`timescale 1ns/1ps
module qbtp_chk (
  input wire logic clock, reset_n, driver_capture_clock,
  input wire logic bus_drive_inhibit, receive_hold, receive_output_disable,
  input wire qbtp_pkg::qbtp_word_type send_word, bus_in,
  input wire qbtp_pkg::qbtp_drive_type bus_out,
  input wire qbtp_pkg::qbtp_recv_type receive_out,
  input wire logic parity_odd
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic rx_on = receive_hold && !receive_output_disable;
  AST_FLOAT: assert property (bus_drive_inhibit[*5] |-> !bus_out.enable)
    else $error("bus driven while inhibited");
  AST_DRIVE: assert property (!bus_drive_inhibit[*5] |-> bus_out.enable)
    else $error("bus not driven");
  AST_ROFF: assert property (receive_output_disable[*5]
    |-> !receive_out.enable) else $error("receive word driven");
  AST_RON: assert property (!receive_output_disable[*5]
    |-> receive_out.enable) else $error("receive word floated");
  AST_GEN: assert property ((!bus_drive_inhibit && $stable(send_word))[*5]
    |-> parity_odd == ^send_word) else $error("generated parity wrong");
  AST_HOLD: assert property (rx_on[*8] |-> $stable(receive_out.data))
    else $error("held word changed");
  AST_CHK: assert property ((bus_drive_inhibit && rx_on)[*8]
    |-> parity_odd == ^receive_out.data) else $error("checked parity wrong");
  AST_KEEP: assert property (!driver_capture_clock[*5]
    |-> $stable(bus_out.data)) else $error("register changed without edge");
  AST_LOOP: assert property ((!driver_capture_clock
    && !bus_drive_inhibit && !receive_hold && !receive_output_disable)[*6]
    |-> receive_out.data == ~bus_out.data) else $error("loopback word wrong");
endmodule
bind qbtp_transceiver qbtp_chk u_qbtp_chk (.clock, .reset_n, .send_word,
  .driver_capture_clock, .bus_drive_inhibit, .receive_hold,
  .receive_output_disable, .bus_in, .bus_out, .receive_out, .parity_odd);

// ---- tb/qbtp_transceiver_tb_top.sv ----
`timescale 1ns/1ps
module qbtp_transceiver_tb_top;
  logic clock = 0, reset_n = 0, cap = 0, inh = 1, hold = 0, oed = 0, par;
  qbtp_pkg::qbtp_word_type send = 0, pv = 0, bus, drv, lat;
  qbtp_pkg::qbtp_drive_type bo;
  qbtp_pkg::qbtp_recv_type ro;
  int miscompares = 0, check_count = 0;
  initial forever #4 clock = ~clock;
  qbtp_transceiver u_qbtp_transceiver (.clock(clock), .reset_n(reset_n),
    .send_word(send), .driver_capture_clock(cap), .bus_drive_inhibit(inh),
    .receive_hold(hold), .receive_output_disable(oed), .bus_in(bus),
    .bus_out(bo), .receive_out(ro), .parity_odd(par));
  qbtp_peer u_qbtp_peer (.clock(clock), .en(inh), .val(pv), .dev(bo),
    .bus(bus));
  task automatic cmp(input logic [4:0] g, input logic [4:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Sixty passes of seventeen cycles each fit well inside this span.
  initial begin
    tick(3000);
    miscompares++;
    test_done;
  end
  initial begin
    void'($urandom(37));
    tick(8);
    reset_n <= 1;
    tick(2);
    for (int i = 0; i < 60; i++) begin
      // Hold settles before the bus moves, so the latch never races it.
      hold <= (i > 0) && $urandom % 2;
      tick(4);
      inh <= 1'($urandom);
      oed <= 1'($urandom);
      send <= 4'($urandom);
      pv <= 4'($urandom);
      tick(4);
      cap <= 1;
      tick(3);
      cap <= 0;
      tick(5);
      // Outputs are looked at mid-cycle, where they have settled.
      @(negedge clock);
      drv = send;
      if (!hold) lat = inh ? ~pv : drv;
      cmp({bo.data, bo.enable}, {~drv, !inh});
      cmp({ro.data, ro.enable}, {lat, !oed});
      cmp({4'h0, par}, {4'h0, inh ? ^lat : ^send});
      tick(1);
    end
    test_done;
  end
endmodule
